/* design/flash_status_pkg.sv */
// constants for the flash write-status polling controller
package flash_status_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 24;
  // status bit positions on the data bus
  localparam int POLL_POS = 7;
  localparam int TOG1_POS = 6;
  localparam int TIMEOUT_POS = 5;
  localparam int WINDOW_POS = 3;
  localparam int TOG2_POS = 2;
  localparam int ABORT_POS = 1;
  // bus cycle phase lengths in clocks minus one
  localparam logic [3:0] ACCESS_CYC = 4'hA;
  localparam logic [3:0] RECOVER_CYC = 4'h2;
  // reset command word driven to the device on timeout failure
  localparam logic [15:0] RESET_CMD = 16'h00F0;
  // result codes
  localparam logic [1:0] RES_OK = 2'h0;
  localparam logic [1:0] RES_FAIL = 2'h1;
  localparam logic [1:0] RES_ABORT = 2'h2;
  typedef enum logic [1:0] {MODE_TOGGLE, MODE_POLL} mode_t;
endpackage : flash_status_pkg

/* design/flash_status_poller.sv */
// host-side controller polling flash write status after program or erase
// Function
// R01: program polling bit inverted until done
// R02: protected program shows busy briefly
// R03: erase polling bit reads zero until done
// R04: all-protected erase busy then array read
// R05: partly protected erase skips protected sectors
// R06: host reads programmed or erased address
// R07: host trusts data only on following read
// R08: first toggle bit inverts per read while busy
// R09: reads strobed by output strobe or select
// R10: erase suspend stops first toggle bit
// R11: protected program toggles about two microseconds
// R12: second toggle bit flips in erased sectors
// R13: toggle status valid after command ends
// R14: timeout flag rises past timing limit
// R15: buffer abort flag rises on abort
// R16: buffered write polls last loaded address
// R17: host compares toggle bit across two reads
// R18: timeout with toggling means fail, reset
// R19: leaving polling restarts whole check
// R20: erase window flag high once erase runs
// R21: ready busy low during embedded operation
// R22: non-suspended sectors return array data
`timescale 1ns/1ps
module flash_status_poller
  #(parameter int AW = flash_status_pkg::ADDR_W,
    parameter int DW = flash_status_pkg::DATA_W)
  (input wire logic clk,
   input wire logic arst_n,
   input wire logic start,
   input wire flash_status_pkg::mode_t mode,
   input wire logic [AW-1:0] pollAddr,
   input wire logic [7:0] expectData,
   input wire logic abandon,
   output logic busy,
   output logic done,
   output logic [1:0] result,
   output logic eraseWindow,
   output logic [AW-1:0] flashAddr,
   output logic ceN,
   output logic oeN,
   output logic weN,
   input wire logic [DW-1:0] dqIn,
   output logic [DW-1:0] dqOut,
   output logic dqOe,
   input wire logic readyBusyN);

  typedef enum logic [2:0] {IDLE, RD, GAP, EVAL, WR, WRGAP} state_t;
  state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;                  // phase counter
  logic [DW-1:0] last_q, last_d;             // previous status word
  logic first_q, first_d;                    // no earlier read yet
  logic sawTo_q, sawTo_d;                    // timeout seen, recheck pending
  logic verify_q, verify_d;                  // one more read for true data
  logic [1:0] res_q, res_d;
  logic done_q, done_d;
  logic win_q, win_d;
  logic [AW-1:0] addr_q, addr_d;
  flash_status_pkg::mode_t mode_q, mode_d;
  logic [DW-1:0] dq_q;                       // read sample
  logic [DW-1:0] cur;

  // the first toggle bit moved between two reads
  function automatic logic toggled(input logic [DW-1:0] a, input logic [DW-1:0] b);
    toggled = a[flash_status_pkg::TOG1_POS] != b[flash_status_pkg::TOG1_POS];
  endfunction : toggled

  assign cur = dq_q;

  // sequencing of reads and decisions
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    last_d = last_q;
    first_d = first_q;
    sawTo_d = sawTo_q;
    verify_d = verify_q;
    res_d = res_q;
    done_d = 1'b0;
    win_d = win_q;
    addr_d = addr_q;
    mode_d = mode_q;
    unique case (state_q)
      IDLE:
      begin
        if (start)
        begin
          addr_d = pollAddr;                 // R06 R16
          mode_d = mode;
          first_d = 1'b1;                    // R19
          sawTo_d = 1'b0;
          verify_d = 1'b0;
          cnt_d = flash_status_pkg::ACCESS_CYC;
          state_d = RD;
        end
      end
      RD:
      begin
        // one read cycle under select plus output strobe
        if (cnt_q == 4'h0)
        begin
          cnt_d = flash_status_pkg::RECOVER_CYC;
          state_d = GAP;
        end
        else
          cnt_d = cnt_q - 4'h1;
      end
      GAP:
      begin
        // strobes high between reads so each read is a new cycle
        if (cnt_q == 4'h0)
          state_d = EVAL;
        else
          cnt_d = cnt_q - 4'h1;
      end
      EVAL:
      begin
        win_d = cur[flash_status_pkg::WINDOW_POS];   // R20
        last_d = cur;
        first_d = 1'b0;
        cnt_d = flash_status_pkg::ACCESS_CYC;
        state_d = RD;
        if (abandon)
        begin
          // leaving means a fresh start next time
          res_d = flash_status_pkg::RES_FAIL;        // R19
          done_d = 1'b1;
          state_d = IDLE;
        end
        else if (verify_q)
        begin
          // data valid only on the read after completion
          res_d = (cur[7:0] == expectData) ? flash_status_pkg::RES_OK
                                           : flash_status_pkg::RES_FAIL; // R07
          done_d = 1'b1;
          state_d = IDLE;
        end
        else if (first_q)
          state_d = RD;                      // R17
        else if (mode_q == flash_status_pkg::MODE_POLL &&
                 cur[flash_status_pkg::POLL_POS] == expectData[flash_status_pkg::POLL_POS])
          verify_d = 1'b1;                   // R01 R03 R07
        else if (mode_q == flash_status_pkg::MODE_TOGGLE && !toggled(cur, last_q))
          verify_d = 1'b1;                   // R17
        else if (cur[flash_status_pkg::ABORT_POS])
        begin
          res_d = flash_status_pkg::RES_ABORT;   // R15
          done_d = 1'b1;
          state_d = IDLE;
        end
        else if (sawTo_q)
        begin
          cnt_d = flash_status_pkg::ACCESS_CYC;
          res_d = flash_status_pkg::RES_FAIL;    // R18
          state_d = WR;
        end
        else if (cur[flash_status_pkg::TIMEOUT_POS])
          sawTo_d = 1'b1;                        // R14 R18
      end
      WR:
      begin
        // reset command write to return device to array read
        if (cnt_q == 4'h0)
        begin
          cnt_d = flash_status_pkg::RECOVER_CYC;
          state_d = WRGAP;
        end
        else
          cnt_d = cnt_q - 4'h1;
      end
      WRGAP:
      begin
        if (cnt_q == 4'h0)
        begin
          done_d = 1'b1;                     // R18
          state_d = IDLE;
        end
        else
          cnt_d = cnt_q - 4'h1;
      end
      default:
        state_d = IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= IDLE;
      cnt_q <= 4'h0;
      last_q <= '0;
      first_q <= 1'b1;
      sawTo_q <= 1'b0;
      verify_q <= 1'b0;
      res_q <= flash_status_pkg::RES_OK;
      done_q <= 1'b0;
      win_q <= 1'b0;
      addr_q <= '0;
      mode_q <= flash_status_pkg::MODE_TOGGLE;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      last_q <= last_d;
      first_q <= first_d;
      sawTo_q <= sawTo_d;
      verify_q <= verify_d;
      res_q <= res_d;
      done_q <= done_d;
      win_q <= win_d;
      addr_q <= addr_d;
      mode_q <= mode_d;
    end
  end

  // pin drive, all registered; sample taken at end of access
  logic ceN_d, oeN_d, weN_d, dqOe_d, busy_d;
  logic [DW-1:0] dq_d;
  always_comb
  begin
    ceN_d = !(state_d == RD || state_d == WR);   // R09
    oeN_d = !(state_d == RD);
    weN_d = !(state_d == WR);
    dqOe_d = (state_d == WR);
    busy_d = (state_d != IDLE);
    dq_d = (state_q == RD && cnt_q == 4'h0) ? dqIn : dq_q;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ceN <= 1'b1;
      oeN <= 1'b1;
      weN <= 1'b1;
      dqOe <= 1'b0;
      busy <= 1'b0;
      dq_q <= '0;
    end
    else
    begin
      ceN <= ceN_d;
      oeN <= oeN_d;
      weN <= weN_d;
      dqOe <= dqOe_d;
      busy <= busy_d;
      dq_q <= dq_d;
    end
  end

  assign flashAddr = addr_q;
  assign dqOut = flash_status_pkg::RESET_CMD[DW-1:0];
  assign done = done_q;
  assign result = res_q;
  assign eraseWindow = win_q;

  // strobes never both low
  a_strobe_excl: assert property (@(posedge clk) disable iff (!arst_n)
    !(!oeN && !weN)) else $error("read and write strobes together"); // R09
  // a finish always follows a busy period
  a_done_busy: assert property (@(posedge clk) disable iff (!arst_n)
    done |-> $past(busy)) else $error("done without busy"); // R17
  // abort result only when abort bit seen
  a_abort_flag: assert property (@(posedge clk) disable iff (!arst_n)
    (done && result == flash_status_pkg::RES_ABORT) |->
      last_q[flash_status_pkg::ABORT_POS]) else $error("abort without flag"); // R15
  // reset write follows a recheck after timeout
  a_reset_write: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(weN) |-> $past(sawTo_q, 2)) else $error("reset write without timeout"); // R18
  // read strobe stays low at least eight clocks
  a_read_len: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(oeN) |-> !oeN [*8]) else $error("read strobe too short"); // R07
  // strobes rise between reads
  a_read_gap: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(oeN) |-> oeN [*2]) else $error("no gap between reads"); // R17
  // driving data only while writing
  a_drive_write: assert property (@(posedge clk) disable iff (!arst_n)
    dqOe |-> !weN) else $error("bus driven outside write"); // R18
  // select low whenever a strobe is low
  a_select_low: assert property (@(posedge clk) disable iff (!arst_n)
    (!oeN || !weN) |-> !ceN) else $error("strobe without select"); // R09
endmodule : flash_status_poller

/* testbench/flash_device_model.sv */
// behavioural flash device answering status reads
`timescale 1ns/1ps
module flash_device_model
  (input wire logic ceN,
   input wire logic oeN,
   input wire logic weN,
   input wire logic [15:0] dqOut,
   output logic [15:0] dqIn,
   output logic readyBusyN,
   input wire logic arm,
   input wire logic isErase,
   input wire logic [7:0] datum,
   input wire logic [7:0] busyReads,
   input wire logic timedOut,
   input wire logic aborted,
   input wire logic kept);
  logic running = 1'b0; // embedded algorithm active
  logic [7:0] left = 8'h00; // reads until completion
  logic tog1 = 1'b0;
  logic tog2 = 1'b0;
  logic [15:0] word; // array or status value
  wire reading = ~ceN & ~oeN; // either strobe rising ends a read
  // the bench arms a new operation
  always @(posedge arm)
  begin
    running = 1'b1;
    left = busyReads;
  end
  // each finished read flips the toggle bits while busy
  always @(negedge reading)
  begin
    if (running)
    begin
      tog1 = ~tog1;
      tog2 = ~tog2;
      if (left != 8'h00)
        left = left - 8'h01;
      else if (!timedOut && !aborted) // a stuck operation ends only on the reset command
        running = 1'b0;
    end
  end
  // select and write strobe rise in one step, so latch on the combined cycle end
  wire writing = ~ceN & ~weN; // either strobe rising ends a write
  // reset command returns to array read
  always @(negedge writing)
  begin
    if (dqOut[7:0] == 8'hF0)
      running = 1'b0;
  end
  // status while busy, array data when done
  always_comb
  begin
    if (running)
      word = {8'h00, ~isErase & ~datum[7], tog1, timedOut, 1'b0,
              isErase, isErase & tog2, aborted, 1'b0};
    else if (kept)
      word = 16'h0000; // protected target keeps its stale content
    else if (isErase)
      word = 16'hFFFF;
    else
      word = {8'h00, datum};
  end
  // released bus shows the inverse so a stale value never passes
  assign dqIn = reading ? word : ~word;
  assign readyBusyN = ~running;
endmodule : flash_device_model

/* testbench/flash_status_poller_test.sv */
// self-checking bench for the flash status poller
`timescale 1ns/1ps
module flash_status_poller_test;
  localparam flash_status_pkg::mode_t TG = flash_status_pkg::MODE_TOGGLE;
  localparam flash_status_pkg::mode_t PL = flash_status_pkg::MODE_POLL;
  localparam logic [1:0] OK = flash_status_pkg::RES_OK;
  localparam logic [1:0] FL = flash_status_pkg::RES_FAIL;
  localparam logic [1:0] AB = flash_status_pkg::RES_ABORT;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  logic abandon = 1'b0;
  flash_status_pkg::mode_t mode = TG;
  logic [23:0] pollAddr = 24'h000100;
  logic [7:0] expectData = 8'h00;
  logic busy, done, eraseWindow, ceN, oeN, weN, dqOe, readyBusyN;
  logic [1:0] result;
  logic [23:0] flashAddr;
  logic [15:0] dqIn, dqOut;
  // device model controls
  logic arm = 1'b0;
  logic isErase = 1'b0;
  logic [7:0] datum = 8'h35;
  logic [7:0] busyReads = 8'h00;
  logic timedOut = 1'b0;
  logic aborted = 1'b0;
  logic kept = 1'b0; // target sector protected, nothing changes
  logic wrote = 1'b0; // reset command seen
  int fails = 0;
  int numChecks = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  flash_status_poller dut (.clk(clk), .arst_n(arst_n), .start(start), .mode(mode),
    .pollAddr(pollAddr), .expectData(expectData), .abandon(abandon), .busy(busy),
    .done(done), .result(result), .eraseWindow(eraseWindow), .flashAddr(flashAddr),
    .ceN(ceN), .oeN(oeN), .weN(weN), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
    .readyBusyN(readyBusyN));
  flash_device_model dev (.ceN(ceN), .oeN(oeN), .weN(weN), .dqOut(dqOut), .dqIn(dqIn),
    .readyBusyN(readyBusyN), .arm(arm), .isErase(isErase), .datum(datum),
    .busyReads(busyReads), .timedOut(timedOut), .aborted(aborted), .kept(kept));
  // catch the reset command word on a write cycle
  always @(posedge clk)
  begin
    if (!weN && !ceN && dqOe && dqOut === flash_status_pkg::RESET_CMD)
      wrote <= 1'b1;
  end
  // hang guard, far above the longest expected run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fails++;
      conclude();
    end
  end
  // verdict and end of run
  task automatic conclude();
    if (fails == 0 && numChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  // one comparison of any design value
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // one polling job; tab holds abandon, abort and timeout
  task automatic run(input flash_status_pkg::mode_t m, input logic e, input logic [7:0] n,
                     input logic [2:0] tab, input logic [7:0] x, input logic [1:0] r);
    int k;
    mode = m;
    isErase = e;
    busyReads = n;
    timedOut = tab[0];
    aborted = tab[1];
    expectData = x;
    pollAddr = pollAddr + 24'h010000;
    wrote = 1'b0;
    arm = 1'b1;
    start = 1'b1;
    @(posedge clk);
    #1 arm = 1'b0;
    start = 1'b0;
    cmp(24'(busy), 24'h1);
    // bounded wait for the completion pulse
    for (k = 0; k < 3000 && done !== 1'b1; k++)
    begin
      abandon = tab[2] && k > 60;
      @(posedge clk);
      #1;
    end
    abandon = 1'b0;
    cmp(24'(done), 24'h1);
    cmp(24'(busy), 24'h0);
    cmp(24'(result), 24'(r));
    cmp(flashAddr, pollAddr);
    cmp(24'(wrote), 24'(tab[0]));
    cmp(24'(readyBusyN), 24'(!tab[1] && !tab[2]));
    cmp(24'(eraseWindow), 24'(e && !kept));
  endtask : run
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    run(TG, 1'b0, 8'h03, 3'b000, 8'h35, OK);
    run(PL, 1'b0, 8'h03, 3'b000, 8'h35, OK);
    run(PL, 1'b1, 8'h02, 3'b000, 8'hFF, OK);
    run(TG, 1'b1, 8'h04, 3'b000, 8'hFF, OK);
    run(TG, 1'b0, 8'hFF, 3'b001, 8'h35, FL);
    run(TG, 1'b0, 8'hFF, 3'b010, 8'h35, AB);
    run(TG, 1'b0, 8'h02, 3'b000, 8'h36, FL);
    run(TG, 1'b0, 8'hFF, 3'b100, 8'h35, FL);
    run(PL, 1'b0, 8'h00, 3'b000, 8'h35, OK);
    kept = 1'b1;
    run(TG, 1'b0, 8'h01, 3'b000, 8'h35, FL);
    run(PL, 1'b0, 8'h01, 3'b000, 8'h35, FL);
    run(TG, 1'b1, 8'h02, 3'b000, 8'hFF, FL);
    kept = 1'b0;
    conclude();
  end
endmodule : flash_status_poller_test
